// ### design/aems_bank.sv
// AER uncorrectable mask/severity and correctable status bank with AHB-Lite slave
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Function
// R1 - Suppress bit 0 stops logging and messages for training errors; resets zero.
// R2 - Suppress bit 4 stops logging and messages for data link protocol errors.
// R3 - Suppress bit 12 stops logging and messages for poisoned TLPs, received or generated.
// R4 - Bits 13, 14, 15 suppress flow control, completion timeout, completer abort.
// R5 - Bit 16 suppresses unexpected completions, bit 17 receiver overflow; reset zero.
// R6 - Bits 18-20 suppress malformed, ECRC, unsupported request; bits above 20 read zero.
// R7 - Fatality bit one means fatal; training, DL, FC, overflow, malformed reset fatal.
// R8 - Correctable bit 0 sets on receiver error; write one clears; resets zero.
// R9 - Correctable bit 6 sets on bad TLP, bit 7 on bad DLLP; W1C.
// R10 - Correctable bit 8 sets on replay counter rollover; W1C.
// R11 - Correctable bit 12 sets on replay timer expiry; other bits read zero.
// R12 - Mask, fatality and correctable flags survive hot reset; only power-on resets them.
// R13 - Fatality bit of an unmasked error picks fatal or non-fatal message.
module aems_bank (
  // Clock and power-on reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // Conventional / hot reset from the link core, one-cycle pulse
  input  wire logic                          hot_reset,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [aems_pkg::AEMS_ADDR_W-1:0] haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [aems_pkg::AEMS_DATA_W-1:0] hwdata,
  input  wire logic                          hready,
  output logic [aems_pkg::AEMS_DATA_W-1:0]   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // Error event strobes, one cycle, same clock domain
  input  wire logic [31:0]                   unc_err_evt,
  input  wire logic [31:0]                   cor_err_evt,
  // Header log and error message requests toward the logging path
  output logic                               hdr_log_req,
  output logic [31:0]                        hdr_log_vec,
  output logic                               msg_fatal,
  output logic                               msg_nonfatal,
  // Interrupt
  output logic                               irq
);

  import aems_pkg::*;

  // Bus state and captured address phase
  aems_bus_st_t         bus_st_q;
  aems_bus_st_t         bus_st_d;
  logic [AEMS_ADDR_W-1:0] addr_q;
  logic [AEMS_DATA_W-1:0] hrdata_q;

  // Register contents
  logic [31:0]          suppress_q;
  logic [31:0]          fatality_q;
  logic [31:0]          cor_flag;
  logic [AEMS_IRQ_W-1:0] irq_stat;
  logic [AEMS_IRQ_W-1:0] irq_mask_q;

  // Message path flops
  logic                 log_req_q;
  logic [31:0]          log_vec_q;
  logic                 fatal_q;
  logic                 nonfatal_q;

  // Address-phase acceptance; hsize is not checked, only words are expected
  wire                  take    = hsel & htrans[1] & hready;
  wire                  in_wr   = (bus_st_q == BUS_WRITE);
  wire                  in_rdw  = (bus_st_q == BUS_RD_WAIT);
  wire [9:0]            widx    = addr_q[11:2];

  // Register selects from the captured address
  wire                  sel_sup = (widx == AEMS_OFF_SUPPRESS[11:2]);
  wire                  sel_fat = (widx == AEMS_OFF_FATALITY[11:2]);
  wire                  sel_cor = (widx == AEMS_OFF_COR_FLAG[11:2]);
  wire                  sel_ist = (widx == AEMS_OFF_IRQ_STAT[11:2]);
  wire                  sel_imk = (widx == AEMS_OFF_IRQ_MASK[11:2]);

  // Write and read-side strobes
  wire                  wr_sup  = in_wr & sel_sup;
  wire                  wr_fat  = in_wr & sel_fat;
  wire                  wr_cor  = in_wr & sel_cor;
  wire                  wr_imk  = in_wr & sel_imk;
  wire                  rd_ist  = in_rdw & sel_ist;

  // Unmasked uncorrectable events and their class
  wire [31:0]           unc_hit   = unc_err_evt & AEMS_UNC_IMPL & ~suppress_q; // see R1 R2 R3 R4 R5 R6
  wire                  hit_any   = |unc_hit;
  wire                  hit_fatal = |(unc_hit & fatality_q);                   // see R13
  wire                  hit_nfat  = |(unc_hit & ~fatality_q);                  // see R13

  // Correctable flag set/clear strobes
  wire [31:0]           cor_set   = cor_err_evt & AEMS_COR_IMPL;               // see R8 R9 R10 R11
  wire [31:0]           cor_clr   = wr_cor ? hwdata : 32'h00000000;            // see R8 R9 R10

  // Interrupt events and read-to-clear
  wire [AEMS_IRQ_W-1:0] irq_set   = {|cor_set, hit_nfat, hit_fatal};
  wire [AEMS_IRQ_W-1:0] irq_clr   = rd_ist ? {AEMS_IRQ_W{1'b1}} : {AEMS_IRQ_W{1'b0}};

  // Read mux; reserved bits are already zero in the stored values
  wire [31:0]           rd_word   = sel_sup ? suppress_q :
                                    sel_fat ? fatality_q :
                                    sel_cor ? cor_flag :
                                    sel_ist ? {29'h0, irq_stat} :
                                    sel_imk ? {29'h0, irq_mask_q} :
                                    32'h00000000;

  // Next bus state; reads take one wait state so a preceding write is seen
  always_comb
  begin
    case (bus_st_q)
      BUS_RD_WAIT:
        bus_st_d = BUS_RD_DONE;
      BUS_IDLE,
      BUS_WRITE,
      BUS_RD_DONE:
        if (take)
          bus_st_d = hwrite ? BUS_WRITE : BUS_RD_WAIT;
        else
          bus_st_d = BUS_IDLE;
      default:
        bus_st_d = BUS_IDLE;
    endcase
  end

  // Bus handshake outputs
  assign hreadyout = ~in_rdw;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // Bus state and address capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_st_q <= BUS_IDLE;
      addr_q   <= '0;
    end
    else
    begin
      bus_st_q <= bus_st_d;
      if (take)
        addr_q <= haddr;
    end
  end

  // Read data latched at the end of the wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h00000000;
    else if (in_rdw)
      hrdata_q <= rd_word;
  end

  // Sticky mask and fatality; hot reset deliberately does not touch them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      suppress_q <= AEMS_SUPPRESS_RST;                    // see R1 R5 R12
      fatality_q <= AEMS_FATALITY_RST;                    // see R7 R12
    end
    else
    begin
      if (wr_sup)
        suppress_q <= hwdata & AEMS_UNC_IMPL;             // see R6
      if (wr_fat)
        fatality_q <= hwdata & AEMS_UNC_IMPL;             // see R7
    end
  end

  // Sticky correctable flags: only power-on reset clears them besides W1C
  aems_flag_bank #(
    .W    (32),
    .IMPL (AEMS_COR_IMPL)
  ) u_cor_flags (
    .clk      (hclk),
    .rst_n    (hresetn),
    .bank_clr (1'b0),                                     // see R12
    .set      (cor_set),
    .clr      (cor_clr),
    .q        (cor_flag)
  );

  // Interrupt status is not sticky, so a hot reset drops it
  aems_flag_bank #(
    .W    (AEMS_IRQ_W),
    .IMPL ({AEMS_IRQ_W{1'b1}})
  ) u_irq_stat (
    .clk      (hclk),
    .rst_n    (hresetn),
    .bank_clr (hot_reset),
    .set      (irq_set),
    .clr      (irq_clr),
    .q        (irq_stat)
  );

  // Interrupt mask: a one enables the matching status bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_mask_q <= AEMS_IRQ_MASK_RST;
    else if (hot_reset)
      irq_mask_q <= AEMS_IRQ_MASK_RST;
    else if (wr_imk)
      irq_mask_q <= hwdata[AEMS_IRQ_W-1:0];
  end

  assign irq = |(irq_stat & irq_mask_q);

  // Logging and message requests, registered one cycle after the event
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      log_req_q  <= 1'b0;
      log_vec_q  <= 32'h00000000;
      fatal_q    <= 1'b0;
      nonfatal_q <= 1'b0;
    end
    else if (hot_reset)
    begin
      log_req_q  <= 1'b0;
      log_vec_q  <= 32'h00000000;
      fatal_q    <= 1'b0;
      nonfatal_q <= 1'b0;
    end
    else
    begin
      log_req_q  <= hit_any;                              // see R1 R2 R3 R4 R5 R6
      log_vec_q  <= unc_hit;
      fatal_q    <= hit_fatal;                            // see R13
      nonfatal_q <= hit_nfat;                             // see R13
    end
  end

  assign hdr_log_req  = log_req_q;
  assign hdr_log_vec  = log_vec_q;
  assign msg_fatal    = fatal_q;
  assign msg_nonfatal = nonfatal_q;

endmodule

`default_nettype wire

// ### design/aems_pkg.sv
// Package: register map, field layouts, reset values and bus states of the AER mask/severity bank
package aems_pkg;

  // Register bus geometry
  localparam int          AEMS_ADDR_W = 12;
  localparam int          AEMS_DATA_W = 32;
  localparam int          AEMS_IRQ_W  = 3;

  // Register byte offsets
  localparam logic [11:0] AEMS_OFF_SUPPRESS = 12'h108;
  localparam logic [11:0] AEMS_OFF_FATALITY = 12'h10C;
  localparam logic [11:0] AEMS_OFF_COR_FLAG = 12'h110;
  localparam logic [11:0] AEMS_OFF_IRQ_STAT = 12'h130;
  localparam logic [11:0] AEMS_OFF_IRQ_MASK = 12'h134;

  // Uncorrectable event bit positions
  localparam int AEMS_UNC_TRAINING   = 0;
  localparam int AEMS_UNC_DL_PROTO   = 4;
  localparam int AEMS_UNC_POISONED   = 12;
  localparam int AEMS_UNC_FC_PROTO   = 13;
  localparam int AEMS_UNC_CPL_TMO    = 14;
  localparam int AEMS_UNC_CPL_ABORT  = 15;
  localparam int AEMS_UNC_UNEXP_CPL  = 16;
  localparam int AEMS_UNC_RX_OVFL    = 17;
  localparam int AEMS_UNC_MALFORMED  = 18;
  localparam int AEMS_UNC_ECRC       = 19;
  localparam int AEMS_UNC_UNSUP_REQ  = 20;

  // Correctable event bit positions
  localparam int AEMS_COR_RX_ERR     = 0;
  localparam int AEMS_COR_BAD_TLP    = 6;
  localparam int AEMS_COR_BAD_DLLP   = 7;
  localparam int AEMS_COR_REPLAY_ROLL = 8;
  localparam int AEMS_COR_REPLAY_TMO = 12;

  // Interrupt status / mask bit positions
  localparam int AEMS_IRQ_FATAL      = 0;
  localparam int AEMS_IRQ_NONFATAL   = 1;
  localparam int AEMS_IRQ_COR        = 2;

  // Implemented bits; everything else reads zero
  localparam logic [31:0] AEMS_UNC_IMPL   = 32'h001FF011;
  localparam logic [31:0] AEMS_COR_IMPL   = 32'h000011C1;

  // Reset values
  localparam logic [31:0] AEMS_SUPPRESS_RST = 32'h00000000;
  localparam logic [31:0] AEMS_FATALITY_RST = 32'h00062011;
  localparam logic [2:0]  AEMS_IRQ_MASK_RST = 3'h0;

  // Bus data-phase states
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_RD_WAIT,
    BUS_RD_DONE
  } aems_bus_st_t;

endpackage

// ### design/aems_flag_bank.sv
// Bank of sticky event flags: hardware sets, a clear strobe clears, set wins
`timescale 1ns/1ps
`default_nettype none

module aems_flag_bank #(
  parameter int            W    = 32,
  parameter logic [W-1:0]  IMPL = '1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Whole-bank clear, for flags that a warm reset must drop
  input  wire logic         bank_clr,
  // Per-bit set and clear strobes
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // Flag values
  output logic      [W-1:0] q
);

  genvar i;

  // One flop per implemented bit; unimplemented bits are tied low
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      if (IMPL[i])
      begin : g_impl
        logic flag_q;

        // Set beats clear so an event in the clearing cycle is kept
        always_ff @(posedge clk or negedge rst_n)
        begin
          if (!rst_n)
            flag_q <= 1'b0;
          else if (set[i])
            flag_q <= 1'b1;
          else if (clr[i] || bank_clr)
            flag_q <= 1'b0;
        end

        // Each implemented bit is driven from its own flop by a continuous assignment
        assign q[i] = flag_q;
      end
      else
      begin : g_rsvd
        assign q[i] = 1'b0;
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ### verif/aems_assertions.sv
// Port checker for the AER mask/severity bank
`timescale 1ns/1ps
`default_nettype none

module aems_assertions (
  // Clock, resets and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hot_reset,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Event path and interrupt
  input wire logic [31:0] unc_err_evt,
  input wire logic        hdr_log_req,
  input wire logic [31:0] hdr_log_vec,
  input wire logic        msg_fatal,
  input wire logic        msg_nonfatal,
  input wire logic        irq
);
  import aems_pkg::*;
  logic        wp_q;
  logic [11:0] wa_q;
  logic [31:0] sup_q;
  logic [31:0] fat_q;
  logic [31:0] exp_q;
  logic        f_q;
  logic        n_q;
  wire  [31:0] live = unc_err_evt & AEMS_UNC_IMPL & ~sup_q;

  // Shadow masks from bus writes; hot reset leaves them, only the log vector and messages drop
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wp_q  <= 1'b0;
      wa_q  <= 12'h000;
      sup_q <= AEMS_SUPPRESS_RST;
      fat_q <= AEMS_FATALITY_RST;
      exp_q <= 32'h00000000;
      f_q   <= 1'b0;
      n_q   <= 1'b0;
    end
    else
    begin
      if (hready)
        wp_q <= hsel && htrans[1] && hwrite;
      if (hready)
        wa_q <= haddr;
      if (wp_q && hready && wa_q == AEMS_OFF_SUPPRESS)
        sup_q <= hwdata & AEMS_UNC_IMPL;
      if (wp_q && hready && wa_q == AEMS_OFF_FATALITY)
        fat_q <= hwdata & AEMS_UNC_IMPL;
      exp_q <= hot_reset ? 32'h00000000 : live;
      f_q   <= !hot_reset && |(live & fat_q);
      n_q   <= !hot_reset && |(live & ~fat_q);
    end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Properties tie log and message outputs to the shadowed cause, then check bus timing, response and hot reset
  a_log_vec_exact: assert property (hdr_log_vec == exp_q)
    else $error("log vector differs from unmasked events");
  a_fatal_msg: assert property (msg_fatal == f_q)
    else $error("fatal message wrong");
  a_nonfatal_msg: assert property (msg_nonfatal == n_q)
    else $error("non-fatal message wrong");
  a_log_req_pair: assert property (hdr_log_req == (hdr_log_vec != 32'h0))
    else $error("log request without vector");
  a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not two cycles");
  a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_hot_quiet: assert property (hot_reset |=> !irq && !hdr_log_req && !msg_fatal)
    else $error("hot reset left outputs active");

  // Main scenarios reached
  c_both_msg: cover property (msg_fatal && msg_nonfatal);
  c_hot: cover property (hot_reset);
  c_irq: cover property ($rose(irq));
endmodule

bind aems_bank aems_assertions u_chk (.hclk, .hresetn, .hot_reset, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .unc_err_evt, .hdr_log_req, .hdr_log_vec,
  .msg_fatal, .msg_nonfatal, .irq);

`default_nettype wire

// ### verif/aems_rc_model.sv
// Root complex stand-in that counts error messages received
`timescale 1ns/1ps
`default_nettype none

module aems_rc_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Messages from the bank
  input  wire logic       msg_fatal,
  input  wire logic       msg_nonfatal,
  // Received counts
  output logic      [7:0] fatal_cnt_q,
  output logic      [7:0] nonfatal_cnt_q
);
  // One pulse is one message; both kinds may land in one cycle
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      fatal_cnt_q    <= 8'h00;
      nonfatal_cnt_q <= 8'h00;
    end
    else
    begin
      fatal_cnt_q    <= fatal_cnt_q + {7'h00, msg_fatal};
      nonfatal_cnt_q <= nonfatal_cnt_q + {7'h00, msg_nonfatal};
    end
endmodule

`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the AER mask/severity bank
`timescale 1ns/1ps
`default_nettype none

module tb;
  import aems_pkg::*;
  typedef struct packed {logic [31:0] s, f, e, v; logic mf, mn;} aems_row_t;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hot_reset = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, unc = 32'h0, cor = 32'h0, hrdata, hdr_log_vec, rd;
  logic        hreadyout, hresp, hdr_log_req, msg_fatal, msg_nonfatal, irq;
  logic [7:0]  f_cnt, n_cnt, ef = 8'h00, en = 8'h00;
  int          err_total = 0, num_checks = 0;
  wire         hready = hreadyout;
  // Suppress, fatality, events in; log vector and messages out
  aems_row_t   rows[5] = '{
    '{32'h0, 32'h00062011, 32'h001FF011, 32'h001FF011, 1'b1, 1'b1},
    '{32'h001FF011, 32'h00062011, 32'h001FF011, 32'h0, 1'b0, 1'b0},
    '{32'h00000011, 32'h0, 32'hFFFFFFFF, 32'h001FF000, 1'b0, 1'b1},
    '{32'h001FF000, 32'hFFFFFFFF, 32'h00000011, 32'h00000011, 1'b1, 1'b0},
    '{32'h000AA000, 32'h00100000, 32'h001FF011, 32'h00155011, 1'b1, 1'b1}};

  aems_bank u_dut (.hclk, .hresetn, .hot_reset, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .unc_err_evt(unc), .cor_err_evt(cor),
    .hdr_log_req, .hdr_log_vec, .msg_fatal, .msg_nonfatal, .irq);
  aems_rc_model u_rc (.hclk, .hresetn, .msg_fatal, .msg_nonfatal, .fatal_cnt_q(f_cnt),
    .nonfatal_cnt_q(n_cnt));

  always #10 hclk = ~hclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  // One single transfer; waits on the slave's own ready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // One-cycle event strobe, then settle to see the registered answer
  task automatic pulse(input logic [31:0] u, input logic [31:0] c);
    @(posedge hclk);
    unc <= u;
    cor <= c;
    @(posedge hclk);
    unc <= 32'h0;
    cor <= 32'h0;
    #1;
  endtask

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, AEMS_OFF_FATALITY, 32'h0, rd);
    chk(rd, 32'h00062011);
    $display("TEST reset done");
    foreach (rows[i])
    begin
      xfer(1'b1, AEMS_OFF_SUPPRESS, rows[i].s, rd);
      xfer(1'b1, AEMS_OFF_FATALITY, rows[i].f, rd);
      xfer(1'b0, AEMS_OFF_SUPPRESS, 32'h0, rd);
      chk(rd, rows[i].s & 32'h001FF011);
      pulse(rows[i].e, 32'h0);
      chk(hdr_log_vec, rows[i].v);
      chk({29'h0, hdr_log_req, msg_fatal, msg_nonfatal},
          {29'h0, rows[i].v != 0, rows[i].mf, rows[i].mn});
      ef += {7'h00, rows[i].mf};
      en += {7'h00, rows[i].mn};
    end
    // The model counts a message at the edge that ends it, one cycle after the pulse shows
    @(posedge hclk);
    #1;
    chk({16'h0, f_cnt, n_cnt}, {16'h0, ef, en});
    $display("TEST rows done");
    pulse(32'h0, 32'hFFFFFFFF);
    xfer(1'b0, AEMS_OFF_COR_FLAG, 32'h0, rd);
    chk(rd, 32'h000011C1);
    xfer(1'b1, AEMS_OFF_COR_FLAG, 32'h00000041, rd);
    xfer(1'b1, AEMS_OFF_COR_FLAG, 32'h0, rd);
    xfer(1'b0, AEMS_OFF_COR_FLAG, 32'h0, rd);
    chk(rd, 32'h00001180);
    $display("TEST flags done");
    // Nonfatal enabled only; bit 0 is nonfatal, bit 20 fatal here
    xfer(1'b1, AEMS_OFF_IRQ_MASK, 32'h2, rd);
    pulse(32'h00000001, 32'h0);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b0, AEMS_OFF_IRQ_STAT, 32'h0, rd);
    // Status still holds the fatal and non-fatal messages of the rows and the correctable burst
    chk(rd, 32'h7);
    chk({31'h0, irq}, 32'h0);
    pulse(32'h00100000, 32'h0);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, 12'h200, 32'hFFFFFFFF, rd);
    xfer(1'b0, 12'h200, 32'h0, rd);
    chk(rd, 32'h0);
    $display("TEST irq done");
    @(posedge hclk);
    hot_reset <= 1'b1;
    @(posedge hclk);
    hot_reset <= 1'b0;
    xfer(1'b0, AEMS_OFF_IRQ_STAT, 32'h0, rd);
    chk(rd, 32'h0);
    xfer(1'b0, AEMS_OFF_COR_FLAG, 32'h0, rd);
    chk(rd, 32'h00001180);
    xfer(1'b0, AEMS_OFF_SUPPRESS, 32'h0, rd);
    chk(rd, 32'h000AA000);
    xfer(1'b0, AEMS_OFF_FATALITY, 32'h0, rd);
    chk(rd, 32'h00100000);
    $display("TEST hot reset done");
    give_verdict();
  end

  // Whole run needs well under 1000 cycles; four times that means a hang
  initial
  begin
    repeat (4000) @(posedge hclk);
    err_total++;
    give_verdict();
  end
endmodule

`default_nettype wire
